// *** verilog/port_mux_pkg.sv ***
// constants for the port alternate-function multiplexer
`default_nettype none
package port_mux_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] OFS_ALT_EN_A = 4'h0;
	localparam logic [3:0] OFS_ALT_SEL_ONE = 4'h1;
	localparam logic [3:0] OFS_ALT_SEL_TWO = 4'h2;
	localparam logic [3:0] OFS_ALT_EN_B = 4'h3;
	localparam logic [3:0] OFS_ALT_EN_D = 4'h4;
	localparam logic [3:0] OFS_PIN_STATE_A = 4'h5;
	// reset values
	localparam logic [7:0] RST_ALT_EN = 8'h00;
	localparam logic [7:0] RST_ALT_SEL = 8'h00;
	// field position of the clock input on port B
	localparam int EXT_CLK_BIT = 3;
endpackage
`default_nettype wire

// *** verilog/port_alt_function_mux_20pin.sv ***
// alternate-function pin multiplexer for port A, B and D of the 20-pin parts
// Notes on behaviour
// - pin A0 select 0 routes timer0 input and complemented timer0 output; 1 reserved.
// - pin A1 select 0 timer0 output; pin A2 select 0 uart0 driver enable; 1 reserved.
// - pin A3 select 0 routes uart0 clear-to-send input; 1 reserved.
// - pin A4 select 0 uart0 receive; select 1 timer2 input and complemented output.
// - pin A5 select 0 uart0 transmit; select 1 timer2 output.
// - pin A6 timer1 in/complement or I2C clock; pin A7 timer1 output or I2C data.
// - second select register exists but never affects port A routing.
// - port D has no select registers; enabling connects its single function directly.
// - external clock enters on port B pin 3 when its alternate function is on.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module port_alt_function_mux_20pin
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	// port A pads
	input wire logic [7:0] padAIn,
	output logic [7:0] padAOut,
	output logic [7:0] padAOe,
	input wire logic [7:0] gpioAOut,
	input wire logic [7:0] gpioAOe,
	output logic [7:0] gpioAIn,
	// port B pin 3 clock input
	input wire logic padB3In,
	output logic externalClockInput,
	output logic [7:0] altEnB,
	// port D pads, one peripheral function each
	input wire logic [7:0] padDIn,
	output logic [7:0] padDOut,
	output logic [7:0] padDOe,
	input wire logic [7:0] gpioDOut,
	input wire logic [7:0] gpioDOe,
	output logic [7:0] gpioDIn,
	input wire logic [7:0] periphDOut,
	input wire logic [7:0] periphDOe,
	output logic [7:0] periphDIn,
	// peripheral signals
	input wire logic timer0Out,
	output logic timer0In,
	input wire logic timer1Out,
	output logic timer1In,
	input wire logic timer2Out,
	output logic timer2In,
	input wire logic uart0DriverEnable,
	output logic uart0ClearToSend,
	output logic uart0ReceiveLine,
	input wire logic uart0TransmitLine,
	input wire logic i2cSclOut,
	input wire logic i2cSclOe,
	output logic i2cSclIn,
	input wire logic i2cSdaOut,
	input wire logic i2cSdaOe,
	output logic i2cSdaIn
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] altEnA_ff;
	logic [7:0] altSelOne_ff;
	logic [7:0] altSelTwo_ff;
	logic [7:0] altEnB_ff;
	logic [7:0] altEnD_ff;
	logic [7:0] regRdata_ff;
	logic [7:0] syncA1_ff;
	logic [7:0] syncA2_ff;
	logic [7:0] syncD1_ff;
	logic [7:0] syncD2_ff;
	logic syncB1_ff;
	logic syncB2_ff;
	logic [7:0] padAOut_ff;
	logic [7:0] padDOut_ff;
	logic [7:0] nxt_padAOut;
	logic [7:0] nxt_padAOe;
	logic [7:0] nxt_padDOut;
	logic [7:0] nxt_padDOe;
	logic [7:0] nxt_regRdata;
	logic [7:0] altA;

	// register writes
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			altEnA_ff <= port_mux_pkg::RST_ALT_EN;
			altSelOne_ff <= port_mux_pkg::RST_ALT_SEL;
			altSelTwo_ff <= port_mux_pkg::RST_ALT_SEL;
			altEnB_ff <= port_mux_pkg::RST_ALT_EN;
			altEnD_ff <= port_mux_pkg::RST_ALT_EN;
		end
		else if (regWrite)
		begin
			if (regAddr == port_mux_pkg::OFS_ALT_EN_A) altEnA_ff <= regWdata;
			if (regAddr == port_mux_pkg::OFS_ALT_SEL_ONE) altSelOne_ff <= regWdata;
			if (regAddr == port_mux_pkg::OFS_ALT_SEL_TWO) altSelTwo_ff <= regWdata;
			if (regAddr == port_mux_pkg::OFS_ALT_EN_B) altEnB_ff <= regWdata;
			if (regAddr == port_mux_pkg::OFS_ALT_EN_D) altEnD_ff <= regWdata;
		end
	end

	// read selection, unmapped reads zero
	assign nxt_regRdata =
		(regAddr == port_mux_pkg::OFS_ALT_EN_A) ? altEnA_ff :
		(regAddr == port_mux_pkg::OFS_ALT_SEL_ONE) ? altSelOne_ff :
		(regAddr == port_mux_pkg::OFS_ALT_SEL_TWO) ? altSelTwo_ff :
		(regAddr == port_mux_pkg::OFS_ALT_EN_B) ? altEnB_ff :
		(regAddr == port_mux_pkg::OFS_ALT_EN_D) ? altEnD_ff :
		(regAddr == port_mux_pkg::OFS_PIN_STATE_A) ? syncA2_ff : 8'h00;

	// read data and pad synchronisers
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			regRdata_ff <= 8'h00;
			syncA1_ff <= 8'h00;
			syncA2_ff <= 8'h00;
			syncD1_ff <= 8'h00;
			syncD2_ff <= 8'h00;
			syncB1_ff <= 1'b0;
			syncB2_ff <= 1'b0;
			padAOut_ff <= 8'h00;
			padDOut_ff <= 8'h00;
		end
		else
		begin
			regRdata_ff <= regRead ? nxt_regRdata : 8'h00;
			syncA1_ff <= padAIn;
			syncA2_ff <= syncA1_ff;
			syncD1_ff <= padDIn;
			syncD2_ff <= syncD1_ff;
			syncB1_ff <= padB3In;
			syncB2_ff <= syncB1_ff;
			padAOut_ff <= nxt_padAOut;
			padDOut_ff <= nxt_padDOut;
		end
	end

	assign regRdata = regRdata_ff;
	assign altEnB = altEnB_ff;

	// ----------------------------------------
	// port A routing
	// ----------------------------------------
	// alternate path only where enabled; select alone does nothing
	assign altA = altEnA_ff;
	// peripheral drive per pin, reserved selects leave the pin undriven
	assign nxt_padAOut[0] = altA[0] ? ~timer0Out : gpioAOut[0];
	assign nxt_padAOe[0] = altA[0] ? ~altSelOne_ff[0] : gpioAOe[0];
	assign nxt_padAOut[1] = altA[1] ? timer0Out : gpioAOut[1];
	assign nxt_padAOe[1] = altA[1] ? ~altSelOne_ff[1] : gpioAOe[1];
	assign nxt_padAOut[2] = altA[2] ? uart0DriverEnable : gpioAOut[2];
	assign nxt_padAOe[2] = altA[2] ? ~altSelOne_ff[2] : gpioAOe[2];
	assign nxt_padAOut[3] = altA[3] ? 1'b0 : gpioAOut[3];
	assign nxt_padAOe[3] = altA[3] ? 1'b0 : gpioAOe[3];
	assign nxt_padAOut[4] = altA[4] ? ~timer2Out : gpioAOut[4];
	assign nxt_padAOe[4] = altA[4] ? altSelOne_ff[4] : gpioAOe[4];
	assign nxt_padAOut[5] = altA[5] ? (altSelOne_ff[5] ? timer2Out : uart0TransmitLine) : gpioAOut[5];
	assign nxt_padAOe[5] = altA[5] ? 1'b1 : gpioAOe[5];
	assign nxt_padAOut[6] = altA[6] ? (altSelOne_ff[6] ? i2cSclOut : ~timer1Out) : gpioAOut[6];
	assign nxt_padAOe[6] = altA[6] ? (altSelOne_ff[6] ? i2cSclOe : 1'b1) : gpioAOe[6];
	assign nxt_padAOut[7] = altA[7] ? (altSelOne_ff[7] ? i2cSdaOut : timer1Out) : gpioAOut[7];
	assign nxt_padAOe[7] = altA[7] ? (altSelOne_ff[7] ? i2cSdaOe : 1'b1) : gpioAOe[7];
	assign padAOut = padAOut_ff;
	assign padAOe = nxt_padAOe;

	// inputs to peripherals, uart0 and I2C inputs idle high and timer inputs idle low when not routed
	assign timer0In = (altA[0] & ~altSelOne_ff[0]) ? syncA2_ff[0] : 1'b0;
	assign uart0ClearToSend = (altA[3] & ~altSelOne_ff[3]) ? syncA2_ff[3] : 1'b1;
	assign uart0ReceiveLine = (altA[4] & ~altSelOne_ff[4]) ? syncA2_ff[4] : 1'b1;
	assign timer2In = (altA[4] & altSelOne_ff[4]) ? syncA2_ff[4] : 1'b0;
	assign timer1In = (altA[6] & ~altSelOne_ff[6]) ? syncA2_ff[6] : 1'b0;
	assign i2cSclIn = (altA[6] & altSelOne_ff[6]) ? syncA2_ff[6] : 1'b1;
	assign i2cSdaIn = (altA[7] & altSelOne_ff[7]) ? syncA2_ff[7] : 1'b1;
	assign gpioAIn = syncA2_ff;

	// ----------------------------------------
	// port B clock input and port D
	// ----------------------------------------
	assign externalClockInput = altEnB_ff[port_mux_pkg::EXT_CLK_BIT] & syncB2_ff;
	// port D: enable alone picks the single function
	assign nxt_padDOut = (altEnD_ff & periphDOut) | (~altEnD_ff & gpioDOut);
	assign nxt_padDOe = (altEnD_ff & periphDOe) | (~altEnD_ff & gpioDOe);
	assign padDOut = padDOut_ff;
	assign padDOe = nxt_padDOe;
	assign periphDIn = altEnD_ff & syncD2_ff;
	assign gpioDIn = syncD2_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_gpio_when_off: assert property (@(posedge clock) disable iff (sys_rst)
		!altA[2] |-> padAOe[2] == gpioAOe[2]) else $error("pin A2 not gpio when disabled");
	a_sel_needs_en: assert property (@(posedge clock) disable iff (sys_rst)
		(!altA[6] && altSelOne_ff[6]) |-> padAOe[6] == gpioAOe[6]) else $error("select leaked without enable");
	a_sel_two_inert: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[5] && $stable(altSelOne_ff) && $stable(timer2Out) && $stable(uart0TransmitLine)
		&& !$stable(altSelTwo_ff)) |=> $stable(padAOut[5])) else $error("second select changed routing");
	a_a0_timer: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[0] && !altSelOne_ff[0] && $stable(altA[0]) && $stable(altSelOne_ff[0]))
		|-> padAOut[0] == ~$past(timer0Out)) else $error("timer0 complement not on A0");
	a_a1_timer: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[1] && !altSelOne_ff[1]) |-> padAOe[1]) else $error("A1 not driven by timer0");
	a_a3_cts: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[3] && !altSelOne_ff[3]) |-> (uart0ClearToSend == syncA2_ff[3] && !padAOe[3]))
		else $error("clear-to-send routing wrong");
	a_a4_select: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[4] && altSelOne_ff[4]) |-> (timer2In == syncA2_ff[4] && uart0ReceiveLine)) else $error("A4 select 1 wrong");
	a_a5_select: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[5] && !altSelOne_ff[5] && $past(altA[5]) && !$past(altSelOne_ff[5]))
		|-> padAOut[5] == $past(uart0TransmitLine)) else $error("A5 transmit not routed");
	a_a6_i2c: assert property (@(posedge clock) disable iff (sys_rst)
		(altA[6] && altSelOne_ff[6]) |-> (padAOe[6] == i2cSclOe && i2cSclIn == syncA2_ff[6])) else $error("A6 I2C wrong");
	a_port_d: assert property (@(posedge clock) disable iff (sys_rst)
		altEnD_ff[0] |-> (padDOe[0] == periphDOe[0] && periphDIn[0] == syncD2_ff[0])) else $error("port D not direct");
	a_clk_in: assert property (@(posedge clock) disable iff (sys_rst)
		!altEnB_ff[port_mux_pkg::EXT_CLK_BIT] |-> !externalClockInput) else $error("clock input leaked");
endmodule
`default_nettype wire

// *** dv/pin_board_model.sv ***
// board-side model: port A pad resolution and an external clock source on port B pin 3
`timescale 1ns/10ps
`default_nettype none
module pin_board_model
(
	input wire logic [7:0] padAOut,
	input wire logic [7:0] padAOe,
	input wire logic [7:0] boardA,
	input wire logic clkOn,
	output logic [7:0] padAIn,
	output logic padB3In
);
	// pad level: the device drive wins, else the board drive
	assign padAIn = (padAOe & padAOut) | (~padAOe & boardA);
	// external logic-level clock, still while switched off, phase unrelated to the core clock
	initial
	begin
		padB3In = 1'b0;
		forever #36 if (clkOn) padB3In = ~padB3In;
	end
endmodule
`default_nettype wire

// *** dv/port_alt_function_mux_20pin_tb_top.sv ***
// self-checking bench for the port alternate-function multiplexer
`timescale 1ns/10ps
`default_nettype none
module port_alt_function_mux_20pin_tb_top;
	logic clock = 1'b0;
	logic regReadD = 1'b0;
	logic sysRst, regWrite, regRead, clkOn, externalClockInput, padB3In;
	logic [1:0] b3Hist;
	logic [3:0] regAddr;
	logic [8:0] per;
	logic [7:0] regWdata, regRdata, padAIn, padAOut, padAOe, gpioAOut, gpioAOe, gpioAIn, boardA, altEnB, en, sel;
	logic [7:0] padDIn, padDOut, padDOe, gpioDOut, gpioDOe, gpioDIn, periphDOut, periphDOe, periphDIn, enD, eoD;
	wire [6:0] insA;
	logic [7:0] expQ[$];
	int nFail = 0;
	int checkCount = 0;
	always #25 clock = ~clock;
	pin_board_model board (.padAOut(padAOut), .padAOe(padAOe), .boardA(boardA), .clkOn(clkOn), .padAIn(padAIn),
		.padB3In(padB3In));
	port_alt_function_mux_20pin uut (.clock(clock), .sys_rst(sysRst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .padAIn(padAIn), .padAOut(padAOut),
		.padAOe(padAOe), .gpioAOut(gpioAOut), .gpioAOe(gpioAOe), .gpioAIn(gpioAIn), .padB3In(padB3In),
		.externalClockInput(externalClockInput), .altEnB(altEnB), .padDIn(padDIn), .padDOut(padDOut),
		.padDOe(padDOe), .gpioDOut(gpioDOut), .gpioDOe(gpioDOe), .gpioDIn(gpioDIn), .periphDOut(periphDOut),
		.periphDOe(periphDOe), .periphDIn(periphDIn), .timer0Out(per[0]), .timer0In(insA[0]), .timer1Out(per[1]),
		.timer1In(insA[1]), .timer2Out(per[2]), .timer2In(insA[2]), .uart0DriverEnable(per[3]),
		.uart0ClearToSend(insA[3]), .uart0ReceiveLine(insA[4]), .uart0TransmitLine(per[4]), .i2cSclOut(per[5]),
		.i2cSclOe(per[6]), .i2cSclIn(insA[5]), .i2cSdaOut(per[7]), .i2cSdaOe(per[8]), .i2cSdaIn(insA[6]));
	// -------------------------------------------
	// shared tasks
	// -------------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			nFail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		expQ.push_back(e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
	endtask
	// port A expectations from enable, select and the stimulus
	task automatic chkA();
		logic [7:0] ao, ad, eo, ed, pad, ei;
		ao = {per[8] | ~sel[7], per[6] | ~sel[6], 1'b1, sel[4], 1'b0, ~sel[2:0]};
		ad = {sel[7] ? per[7] : per[1], sel[6] ? per[5] : ~per[1], sel[5] ? per[2] : per[4], ~per[2], 1'b0, per[3],
			per[0], ~per[0]};
		eo = (en & ao) | (~en & gpioAOe);
		ed = (en & ad) | (~en & gpioAOut);
		pad = (eo & ed) | (~eo & boardA);
		ei = {1'b0, ~(en[7] & sel[7]) | pad[7], ~(en[6] & sel[6]) | pad[6], ~(en[4] & ~sel[4]) | pad[4],
			~(en[3] & ~sel[3]) | pad[3], en[4] & sel[4] & pad[4], en[6] & ~sel[6] & pad[6], en[0] & ~sel[0] & pad[0]};
		check("padAOe", padAOe, eo);
		check("padAOut", padAOut & eo, ed & eo);
		check("gpioAIn", gpioAIn, pad);
		check("peripheral inputs", {1'b0, insA}, ei);
		rd(port_mux_pkg::OFS_PIN_STATE_A, pad);
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge clock)
	begin
		regReadD <= regRead;
		b3Hist <= {b3Hist[0], padB3In};
		if (regReadD)
			check("regRdata", regRdata, expQ.pop_front());
	end
	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial
	begin
		void'($urandom(32'hA36B));
		{sysRst, regWrite, regRead, clkOn} = 4'b1000;
		{regAddr, regWdata, per, boardA, gpioAOut, gpioAOe, en, sel} = '0;
		{padDIn, gpioDOut, gpioDOe, periphDOut, periphDOe} = '0;
		repeat (10) @(posedge clock);
		sysRst <= 1'b0;
		// cleared registers, unmapped place ignored
		for (int a = 0; a < 5; a++)
			rd(4'(a), 8'h00);
		wr(4'hF, 8'hA5);
		rd(4'hF, 8'h00);
		// port A: off, all select 0, all select 1, then random
		for (int k = 0; k < 8; k++)
		begin
			en = (k == 0) ? 8'h00 : (k < 3) ? 8'hFF : 8'($urandom);
			sel = (k == 1) ? 8'h00 : (k == 2) ? 8'hFF : 8'($urandom);
			{per, boardA, gpioAOut, gpioAOe} <= 33'({$urandom, $urandom});
			wr(port_mux_pkg::OFS_ALT_SEL_ONE, sel);
			wr(port_mux_pkg::OFS_ALT_SEL_TWO, ~sel);
			wr(port_mux_pkg::OFS_ALT_EN_A, en);
			rd(port_mux_pkg::OFS_ALT_SEL_TWO, ~sel);
			repeat (4) @(posedge clock);
			chkA();
		end
		// port D: the enable alone connects the single function
		enD = 8'($urandom);
		{padDIn, gpioDOut, gpioDOe, periphDOut} <= $urandom;
		periphDOe <= 8'($urandom);
		wr(port_mux_pkg::OFS_ALT_EN_D, enD);
		rd(port_mux_pkg::OFS_ALT_EN_D, enD);
		repeat (4) @(posedge clock);
		eoD = (enD & periphDOe) | (~enD & gpioDOe);
		check("padDOe", padDOe, eoD);
		check("padDOut", padDOut & eoD, ((enD & periphDOut) | (~enD & gpioDOut)) & eoD);
		check("periphDIn", periphDIn, padDIn & enD);
		check("gpioDIn", gpioDIn, padDIn);
		// port B pin 3: external clock passes only while its function is on
		clkOn <= 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			wr(port_mux_pkg::OFS_ALT_EN_B, j ? 8'h00 : 8'h08);
			repeat (3) @(posedge clock);
			check("altEnB", altEnB, j ? 8'h00 : 8'h08);
			for (int i = 0; i < 40; i++)
			begin
				@(posedge clock);
				check("externalClockInput", {7'h00, externalClockInput}, {7'h00, b3Hist[1] & ~j[0]});
			end
		end
		giveVerdict();
	end
	// watchdog against a hang
	initial
	begin
		repeat (3000) @(posedge clock);
		nFail++;
		giveVerdict();
	end
endmodule
`default_nettype wire
